// *** rtl/fsd_decoder.sv ***
// command-phase decoder and sequencer for seek, scan, sense and set-track commands
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "fsd_map.svh"

module fsd_decoder #(
  parameter int NUM_DRIVES = 4
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire fsd_pkg::fsd_bus_type bus,
  output logic [7:0]              rdData,
  output fsd_pkg::fsd_req_type    req,
  input  wire logic               execDone,
  input  wire logic [7:0]         st0In,
  input  wire logic [7:0]         st1In,
  input  wire logic [7:0]         st2In,
  input  wire logic [7:0]         st3In,
  input  wire logic [7:0]         resTrack,
  input  wire logic [7:0]         resHead,
  input  wire logic [7:0]         resSector,
  input  wire logic [7:0]         resSize,
  input  wire logic               seekTrackValid,
  input  wire logic [11:0]        seekTrack
);
  // the present-track array and two drive-select bits are sized for four drives only
  if (NUM_DRIVES != 4) begin : g_bad_drives
    $error("fsd_decoder serves exactly four drives");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    fsd_pkg::fsd_phase_type phase;
    fsd_pkg::fsd_cmd_type   cmd;
    logic [3:0]             need;
    logic [3:0]             got;
    logic [8:0][7:0]        cmdBytes;
    logic [6:0][7:0]        resBytes;
    logic [3:0]             resLen;
    logic [3:0]             resIdx;
    logic [3:0][11:0]       presentTrack;
    logic                   extendedTrackRange;
    logic                   invalid;
    logic [7:0]             rdData;
    fsd_pkg::fsd_req_type   req;
  } fsd_state_type;

  fsd_state_type s_q;
  fsd_state_type s_d;

  function automatic logic [3:0] cmd_len(input fsd_pkg::fsd_cmd_type c, input logic extended_track_range);
    case (c)
      fsd_pkg::CmdRelSeek:  cmd_len = 4'h2;
      fsd_pkg::CmdSeek:     cmd_len = extended_track_range ? 4'h4 : 4'h3;
      fsd_pkg::CmdScan:     cmd_len = `FSD_LEN_SCAN;
      fsd_pkg::CmdSenseDrv: cmd_len = 4'h2;
      fsd_pkg::CmdSetTrack: cmd_len = 4'h3;
      default:              cmd_len = 4'h1;
    endcase
  endfunction : cmd_len

  function automatic fsd_pkg::fsd_cmd_type decode(input logic [7:0] b);
    if ((b & `FSD_OP_RSEEK_MASK) == `FSD_OP_RSEEK)           decode = fsd_pkg::CmdRelSeek;
    else if (b == `FSD_OP_SEEK)                               decode = fsd_pkg::CmdSeek;
    else if ((b & `FSD_OP_SCAN_MASK) == `FSD_OP_SCAN_EQ)      decode = fsd_pkg::CmdScan;
    else if ((b & `FSD_OP_SCAN_MASK) == `FSD_OP_SCAN_HE)      decode = fsd_pkg::CmdScan;
    else if ((b & `FSD_OP_SCAN_MASK) == `FSD_OP_SCAN_LE)      decode = fsd_pkg::CmdScan;
    else if (b == `FSD_OP_SENSE_DRV)                          decode = fsd_pkg::CmdSenseDrv;
    else if (b == `FSD_OP_SENSE_INT)                          decode = fsd_pkg::CmdSenseInt;
    else if ((b & `FSD_OP_SETTRK_MASK) == `FSD_OP_SETTRK)     decode = fsd_pkg::CmdSetTrack;
    else                                                      decode = fsd_pkg::CmdInvalid;
  endfunction : decode

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic [7:0]  op;
    logic [7:0]  sel;
    logic [1:0]  drv;
    logic [11:0] trk;
    s_d = s_q;
    op  = s_q.cmdBytes[0];
    sel = s_q.cmdBytes[1];
    drv = sel[1:0];
    trk = s_q.presentTrack[drv];
    s_d.req.seekGo = 1'b0;
    s_d.req.scanGo = 1'b0;

    if (bus.wr && bus.addr == `FSD_REG_MODE) begin
      s_d.extendedTrackRange = bus.wdata[`FSD_BIT_ETR];
    end

    if (seekTrackValid) begin
      s_d.presentTrack[s_q.req.drive] = seekTrack;
    end

    case (s_q.phase)
      fsd_pkg::StIdle: begin
        if (bus.wr && bus.addr == `FSD_REG_CMD) begin
          s_d.cmdBytes[0] = bus.wdata;
          s_d.cmd = decode(bus.wdata);
          s_d.need = cmd_len(decode(bus.wdata), s_q.extendedTrackRange);
          s_d.got = 4'h1;
          s_d.invalid = 1'b0;
          s_d.phase = (cmd_len(decode(bus.wdata), s_q.extendedTrackRange) == 4'h1)
                      ? fsd_pkg::StExec : fsd_pkg::StParam;
        end
      end
      fsd_pkg::StParam: begin
        if (bus.wr && bus.addr == `FSD_REG_CMD) begin
          s_d.cmdBytes[s_q.got] = bus.wdata;
          s_d.got = s_q.got + 4'h1;
          if (s_q.got + 4'h1 == s_q.need) begin
            s_d.phase = fsd_pkg::StExec;
          end
        end
      end
      fsd_pkg::StExec: begin
        s_d.resIdx = 4'h0;
        s_d.req.multiTrack = op[7];
        s_d.req.doubleDensitySelect = op[6];
        s_d.req.bypassDeletedSectors = op[5];
        s_d.req.impliedSeek = sel[7];
        s_d.req.headSelect = sel[`FSD_BIT_HEAD];
        s_d.req.drive = drv;
        case (s_q.cmd)
          fsd_pkg::CmdRelSeek: begin
            s_d.req.seekGo = 1'b1;
            s_d.req.relative = 1'b1;
            s_d.req.direction = op[`FSD_BIT_DIR];
            s_d.req.target = {4'h0, s_q.cmdBytes[2]};
            s_d.phase = fsd_pkg::StIdle;
          end
          fsd_pkg::CmdSeek: begin
            s_d.req.seekGo = 1'b1;
            s_d.req.relative = 1'b0;
            s_d.req.target = {s_q.extendedTrackRange ? s_q.cmdBytes[3][7:4] : 4'h0,
                              s_q.cmdBytes[2]};
            s_d.phase = fsd_pkg::StIdle;
          end
          fsd_pkg::CmdScan: begin
            // wait for the compare engine; the request pulses only on entry
            if (!s_q.req.scanGo && !s_q.invalid) begin
              s_d.req.scanGo = 1'b1;
              s_d.req.scanKind = op[3:2];
              s_d.invalid = 1'b1;
            end else if (execDone) begin
              s_d.resBytes = {st0In, st1In, st2In, resTrack, resHead, resSector, resSize};
              s_d.resLen = `FSD_LEN_SCAN_RES;
              s_d.invalid = 1'b0;
              s_d.phase = fsd_pkg::StResult;
            end
          end
          fsd_pkg::CmdSenseDrv: begin
            s_d.resBytes[6] = st3In;
            s_d.resLen = 4'h1;
            s_d.phase = fsd_pkg::StResult;
          end
          fsd_pkg::CmdSenseInt: begin
            s_d.resBytes[6] = st0In;
            s_d.resBytes[5] = trk[7:0];
            s_d.resBytes[4] = {trk[11:8], 4'h0};
            s_d.resLen = s_q.extendedTrackRange ? 4'h3 : 4'h2;
            s_d.phase = fsd_pkg::StResult;
          end
          fsd_pkg::CmdSetTrack: begin
            if ((sel & `FSD_SETTRK_B2_MASK) != `FSD_SETTRK_B2) begin
              s_d.resBytes[6] = `FSD_ST0_INVALID;
            end else if (op[`FSD_BIT_WNR]) begin
              s_d.resBytes[6] = s_q.cmdBytes[2];
              if (sel[`FSD_BIT_MSB]) begin
                s_d.presentTrack[drv][11:8] = s_q.cmdBytes[2][3:0];
              end else begin
                s_d.presentTrack[drv][7:0] = s_q.cmdBytes[2];
              end
            end else begin
              s_d.resBytes[6] = sel[`FSD_BIT_MSB] ? {4'h0, trk[11:8]} : trk[7:0];
            end
            s_d.resLen = 4'h1;
            s_d.phase = fsd_pkg::StResult;
          end
          default: begin
            s_d.resBytes[6] = `FSD_ST0_INVALID;
            s_d.resLen = 4'h1;
            s_d.phase = fsd_pkg::StResult;
          end
        endcase
      end
      fsd_pkg::StResult: begin
        if (bus.rd && bus.addr == `FSD_REG_RESULT) begin
          s_d.resIdx = s_q.resIdx + 4'h1;
          if (s_q.resIdx + 4'h1 == s_q.resLen) begin
            s_d.phase = fsd_pkg::StIdle;
          end
        end
      end
      default: s_d.phase = fsd_pkg::StIdle;
    endcase

    // read data, one cycle after the strobe
    s_d.rdData = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        `FSD_REG_RESULT: s_d.rdData = (s_q.phase == fsd_pkg::StResult)
                                      ? s_q.resBytes[4'h6 - s_q.resIdx] : 8'h00;
        `FSD_REG_STATUS: begin
          s_d.rdData[`FSD_BIT_BUSY] = (s_q.phase != fsd_pkg::StIdle);
          s_d.rdData[`FSD_BIT_RQM]  = (s_q.phase == fsd_pkg::StIdle) ||
                                      (s_q.phase == fsd_pkg::StParam) ||
                                      (s_q.phase == fsd_pkg::StResult);
          s_d.rdData[`FSD_BIT_DIO]  = (s_q.phase == fsd_pkg::StResult);
          s_d.rdData[`FSD_BIT_ERR]  = (s_q.cmd == fsd_pkg::CmdInvalid);
        end
        `FSD_REG_MODE:   s_d.rdData = {7'h00, s_q.extendedTrackRange};
        default:         s_d.rdData = 8'h00;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.phase <= fsd_pkg::StIdle;
      s_q.cmd <= fsd_pkg::CmdNone;
      s_q.presentTrack <= {4{`FSD_TRACK_RESET}};
    end else begin
      s_q <= s_d;
    end
  end

  assign rdData = s_q.rdData;
  assign req    = s_q.req;
endmodule : fsd_decoder

// *** rtl/fsd_map.svh ***
// register offsets, opcodes, field positions and reset values of the seek/scan decoder
`ifndef FSD_MAP_SVH
`define FSD_MAP_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define FSD_REG_CMD      4'h0
`define FSD_REG_RESULT   4'h4
`define FSD_REG_STATUS   4'h8
`define FSD_REG_MODE     4'hC
// ****************************************
// opcodes and match masks
// ****************************************
`define FSD_OP_RSEEK_MASK 8'hBF
`define FSD_OP_RSEEK      8'h8F
`define FSD_OP_SEEK       8'h0F
`define FSD_OP_SCAN_MASK  8'h1F
`define FSD_OP_SCAN_EQ    8'h11
`define FSD_OP_SCAN_HE    8'h1D
`define FSD_OP_SCAN_LE    8'h19
`define FSD_OP_SENSE_DRV  8'h04
`define FSD_OP_SENSE_INT  8'h08
`define FSD_OP_SETTRK_MASK 8'hBF
`define FSD_OP_SETTRK     8'h21
`define FSD_SETTRK_B2_MASK 8'hF8
`define FSD_SETTRK_B2     8'h30
// ****************************************
// field positions
// ****************************************
`define FSD_BIT_DIR      6
`define FSD_BIT_WNR      6
`define FSD_BIT_MSB      2
`define FSD_BIT_HEAD     2
`define FSD_BIT_ETR      0
`define FSD_BIT_BUSY     0
`define FSD_BIT_RQM      1
`define FSD_BIT_DIO      2
`define FSD_BIT_ERR      3
// ****************************************
// byte counts and reset values
// ****************************************
`define FSD_LEN_SCAN     4'h9
`define FSD_LEN_SCAN_RES 4'h7
`define FSD_TRACK_RESET  12'h000
`define FSD_ST0_INVALID  8'h80
`endif

// *** rtl/fsd_pkg.sv ***
// types shared by the seek/scan decoder
package fsd_pkg;
  typedef enum logic [2:0] {
    CmdNone, CmdRelSeek, CmdSeek, CmdScan, CmdSenseDrv, CmdSenseInt, CmdSetTrack, CmdInvalid
  } fsd_cmd_type;

  typedef enum {
    StIdle, StParam, StExec, StResult
  } fsd_phase_type;

  // request to the drive/compare engine
  typedef struct packed {
    logic        seekGo;
    logic        relative;
    logic        direction;
    logic [11:0] target;
    logic        scanGo;
    logic [1:0]  scanKind;
    logic        multiTrack;
    logic        doubleDensitySelect;
    logic        bypassDeletedSectors;
    logic        impliedSeek;
    logic        headSelect;
    logic [1:0]  drive;
  } fsd_req_type;

  // register-port access
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } fsd_bus_type;
endpackage : fsd_pkg

// *** test/floppy_seek_scan_command_decoder_test.sv ***
// self-checking bench for the seek/scan command decoder
`timescale 1ns/1ps
`include "fsd_map.svh"
module floppy_seek_scan_command_decoder_test;
  logic                 sys_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 rdSeen = 1'b0;
  fsd_pkg::fsd_bus_type bus = '0;
  fsd_pkg::fsd_req_type req;
  logic                 execDone, seekTrackValid;
  logic [11:0]          seekTrack;
  logic [7:0]           rdData, st0In, st1In, st2In, st3In, resTrack, resHead, resSector, resSize;
  logic [7:0]           expQ[$], sel, v, h, scanDelay = 8'h01;
  logic [7:0]           ops[3] = '{`FSD_OP_SCAN_EQ, `FSD_OP_SCAN_HE, `FSD_OP_SCAN_LE};
  int                   failures = 0, cmp_count = 0;
  always #5 sys_clk = ~sys_clk;
  fsd_decoder dut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdData(rdData), .req(req),
    .execDone(execDone), .st0In(st0In), .st1In(st1In), .st2In(st2In), .st3In(st3In),
    .resTrack(resTrack), .resHead(resHead), .resSector(resSector), .resSize(resSize),
    .seekTrackValid(seekTrackValid), .seekTrack(seekTrack));
  fsd_engine_model eng (.sys_clk(sys_clk), .rst(rst), .req(req), .scanDelay(scanDelay),
    .execDone(execDone), .seekTrackValid(seekTrackValid), .seekTrack(seekTrack));
  // ****************
  // tasks
  // ****************
  task automatic chk(string n, logic [11:0] s, logic [11:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic put(logic [3:0] a, logic [7:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
  endtask : put
  task automatic gap(int n);
    bus.wr <= 1'b0;
    bus.rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask : gap
  task automatic res(logic [7:0] e[$]);
    foreach (e[i]) begin
      bus <= '{addr: `FSD_REG_RESULT, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      expQ.push_back(e[i]);
      @(posedge sys_clk);
    end
    gap(2);
  endtask : res
  task automatic waitGo();
    int n;
    n = 0;
    gap(0);
    while (req.seekGo !== 1'b1 && req.scanGo !== 1'b1 && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 40) failures++;
    // back onto the rising edge so later stimulus stays edge aligned
    @(posedge sys_clk);
  endtask : waitGo
  task automatic rdReg(logic [3:0] a, logic [7:0] e);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    expQ.push_back(e);
    @(posedge sys_clk);
    gap(2);
  endtask : rdReg
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  // results come one cycle after each read, oldest note first
  always @(posedge sys_clk) rdSeen <= bus.rd;
  always @(negedge sys_clk) if (rdSeen) chk("result", rdData, expQ.pop_front());
  initial begin
    #400000;
    failures++;
    conclude();
  end
  initial begin
    void'($urandom(32'hCA8A));
    {st0In, st1In, st2In, st3In} = $urandom;
    {resTrack, resHead, resSector, resSize} = $urandom;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    for (int e = 0; e < 2; e++) begin
      sel = 8'($urandom);
      v = 8'($urandom);
      h = 8'($urandom);
      put(`FSD_REG_MODE, 8'(e));
      put(`FSD_REG_CMD, `FSD_OP_SEEK);
      put(`FSD_REG_CMD, sel);
      put(`FSD_REG_CMD, v);
      if (e == 1) put(`FSD_REG_CMD, {h[3:0], 4'h0});
      waitGo();
      chk("target", req.target, {(e == 1 ? h[3:0] : 4'h0), v});
      chk("select", {req.impliedSeek, req.headSelect, req.drive}, {sel[7], sel[2:0]});
      gap(3);
      put(`FSD_REG_CMD, `FSD_OP_SENSE_INT);
      gap(3);
      res('{st0In, v, (e == 1 ? {h[3:0], 4'h0} : 8'h00)});
    end
    rdReg(`FSD_REG_MODE, 8'h01);
    $display("seek and sense interrupt done");
    put(`FSD_REG_CMD, {1'b1, v[0], 6'h0F});
    put(`FSD_REG_CMD, sel);
    waitGo();
    chk("relative", {req.relative, req.direction}, {1'b1, v[0]});
    gap(3);
    $display("relative seek done");
    foreach (ops[i]) begin
      scanDelay <= 8'(1 + 8 * i);
      v = 8'($urandom);
      put(`FSD_REG_CMD, {v[7:5], ops[i][4:0]});
      repeat (8) put(`FSD_REG_CMD, 8'($urandom));
      waitGo();
      chk("scan", {req.scanKind, req.multiTrack, req.doubleDensitySelect,
        req.bypassDeletedSectors}, {ops[i][3:2], v[7:5]});
      gap(8 * i + 5);
      res('{st0In, st1In, st2In, resTrack, resHead, resSector, resSize});
    end
    $display("scans done");
    put(`FSD_REG_CMD, `FSD_OP_SENSE_DRV);
    put(`FSD_REG_CMD, sel);
    gap(3);
    res('{st3In, 8'h00});
    $display("sense drive done");
    // write low, read low, write high, read high; reads offer a byte that must not land
    for (int k = 0; k < 4; k++) begin
      put(`FSD_REG_CMD, {1'b0, !k[0], 6'h21});
      put(`FSD_REG_CMD, {5'b00110, k[1], sel[1:0]});
      put(`FSD_REG_CMD, k[0] ? ~v : v);
      gap(3);
      res('{(k == 3 ? {4'h0, v[3:0]} : v)});
    end
    put(`FSD_REG_CMD, 8'hFF);
    gap(3);
    res('{`FSD_ST0_INVALID});
    rdReg(`FSD_REG_STATUS, 8'((1 << `FSD_BIT_RQM) | (1 << `FSD_BIT_ERR)));
    $display("set track and invalid done");
    gap(3);
    conclude();
  end
endmodule : floppy_seek_scan_command_decoder_test

// *** test/fsd_decoder_chk.sv ***
// assertions on the decoder's register port and request outputs
`timescale 1ns/1ps
`include "fsd_map.svh"
module fsd_decoder_chk (
  input wire logic                 sys_clk,
  input wire logic                 rst,
  input wire fsd_pkg::fsd_bus_type bus,
  input wire logic [7:0]           rdData,
  input wire fsd_pkg::fsd_req_type req
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  a_rd_idle_zero:
    assert property (!$past(bus.rd) |-> rdData == 8'h00)
    else $error("read data not zero outside a read slot");
  a_seek_one_pulse:
    assert property (req.seekGo |=> (!req.seekGo) [*2])
    else $error("seek start longer than one cycle");
  a_scan_one_pulse:
    assert property (req.scanGo |=> (!req.scanGo) [*2])
    else $error("scan start longer than one cycle");
  a_go_exclusive:
    assert property (!(req.seekGo && req.scanGo))
    else $error("seek and scan started together");
  a_seek_after_byte:
    assert property (req.seekGo |-> $past(bus.wr, 2) && $past(bus.addr, 2) == `FSD_REG_CMD)
    else $error("seek start not two cycles after last byte");
  a_scan_after_byte:
    assert property (req.scanGo |-> $past(bus.wr, 2) && $past(bus.addr, 2) == `FSD_REG_CMD)
    else $error("scan start not two cycles after last byte");
  a_scan_kind_ok:
    assert property (req.scanGo |-> req.scanKind != 2'b01)
    else $error("scan kind outside the three compares");
  a_target_held:
    assert property (req.seekGo |=> $stable(req.target) && $stable(req.drive))
    else $error("seek target moved right after start");
endmodule : fsd_decoder_chk
bind fsd_decoder fsd_decoder_chk u_chk (.sys_clk(sys_clk), .rst(rst), .bus(bus),
  .rdData(rdData), .req(req));

// *** test/fsd_engine_model.sv ***
// drive and compare engine model on the decoder's request side
`timescale 1ns/1ps
module fsd_engine_model (
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire fsd_pkg::fsd_req_type req,
  input  wire logic [7:0]           scanDelay,
  output logic                      execDone,
  output logic                      seekTrackValid,
  output logic [11:0]               seekTrack
);
  logic [7:0] cnt;
  always @(posedge sys_clk) begin
    seekTrackValid <= 1'b0;
    execDone <= cnt == 8'h01;
    // released track bus toggles so a stale value is never mistaken for data
    seekTrack <= ~seekTrack;
    cnt <= (cnt != 8'h00) ? cnt - 8'h01 : 8'h00;
    if (req.seekGo && !req.relative) begin
      seekTrackValid <= 1'b1;
      seekTrack <= req.target;
    end
    if (req.scanGo) cnt <= scanDelay;
    if (rst) begin
      cnt <= 8'h00;
      seekTrack <= 12'h000;
    end
  end
endmodule : fsd_engine_model
